// *** rtl/four_source_irq_map.svh ***
/*
  register offsets, field positions, reset values and widths of the
  four source interrupt unit.
  assumes: included by bare name, definitions only.
*/
`ifndef FOUR_SOURCE_IRQ_MAP_SVH
`define FOUR_SOURCE_IRQ_MAP_SVH

// ----------------------------------------------------------------
// bus widths, source count and counter widths
// ----------------------------------------------------------------
`define FSI_ADDR_W        4
`define FSI_DATA_W        8
`define FSI_NUM_SRC       4
`define FSI_WIDE_CNT_W    8
`define FSI_NARROW_CNT_W  4

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FSI_ADDR_ENABLE    4'h0
`define FSI_ADDR_STATUS    4'h1
`define FSI_ADDR_PRE_SP    4'h2
`define FSI_ADDR_PRE_HR    4'h3
`define FSI_ADDR_PRE_TM    4'h4
`define FSI_ADDR_RUN       4'h5
`define FSI_ADDR_CNT_SP    4'h6
`define FSI_ADDR_CNT_HR    4'h7
`define FSI_ADDR_CNT_TM    4'h8

// ----------------------------------------------------------------
// source bit positions (enable, status, pending; run for all but external)
// ----------------------------------------------------------------
`define FSI_SRC_SPEECH     0
`define FSI_SRC_HRTIMER    1
`define FSI_SRC_TIMER      2
`define FSI_SRC_EXTERNAL   3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FSI_ENABLE_RST     4'h0
`define FSI_STATUS_RST     4'h0
`define FSI_RUN_RST        3'h0
`define FSI_PRE_WIDE_RST   8'h00
`define FSI_PRE_NARROW_RST 4'h0
`define FSI_RDATA_RST      8'h00
`define FSI_SYNC_RST       3'h0

`endif

// *** rtl/four_source_irq_pkg.sv ***
/*
  types of the four source interrupt unit: bus request carrier and
  the packed state of the top module.
  assumes: four_source_irq_map.svh on the include path.
*/
`include "four_source_irq_map.svh"

package four_source_irq_pkg;

  // ----------------------------------------------------------------
  // register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`FSI_ADDR_W-1:0] addr;
    logic [`FSI_DATA_W-1:0] wdata;
    logic                   we;
    logic                   re;
  } bus_req_s;

  // ----------------------------------------------------------------
  // complete state of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`FSI_NUM_SRC-1:0]      enable;
    logic [`FSI_NUM_SRC-1:0]      status;
    logic [`FSI_WIDE_CNT_W-1:0]   pre_sp;
    logic [`FSI_WIDE_CNT_W-1:0]   pre_hr;
    logic [`FSI_NARROW_CNT_W-1:0] pre_tm;
    logic [2:0]                   run;
    logic [2:0]                   ext_sync;
    logic [`FSI_DATA_W-1:0]       rdata;
  } unit_state_s;

endpackage

// *** rtl/preload_counter.sv ***
/*
  preload counter: counts up from a preload value, pulses terminal at
  the all-ones count and reloads the preload in the same edge.
  assumes: preload and run come from flops on the same clock.
*/
`timescale 1ns/1ps

module preload_counter #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         run,
  input  wire logic [W-1:0] preload,
  output logic      [W-1:0] count,
  output logic              terminal
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tc;
  } cnt_state_s;

  cnt_state_s q;
  cnt_state_s d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d    = q;
    d.tc = 1'b0;
    if (!run) begin
      d.cnt = preload;
    end else if (q.cnt == {W{1'b1}}) begin
      d.cnt = preload;
      d.tc  = 1'b1;
    end else begin
      d.cnt = q.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count    = q.cnt;
  assign terminal = q.tc;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tc_reloads: assert property (terminal |-> count == $past(preload))
    else $error("terminal without reload of preload");
  a_tc_cause: assert property (terminal |-> $past(run) && $past(count) == {W{1'b1}})
    else $error("terminal not caused by all-ones count");
  a_count_steps: assert property (run && !terminal && $past(run) |-> ##0
      (count == $past(count) + {{(W-1){1'b0}}, 1'b1}))
    else $error("counter did not advance by one");

endmodule

// *** rtl/four_source_interrupt_unit.sv ***
/*
  four source interrupt unit: speech and high resolution counters,
  general timer counter, external rising-edge pad; per source enable,
  sticky status flags and one combined request to the core.
  assumes: core drives the register port on clk; the pad is async.
*/
// Implementation choices: the address map and the plain strobed port.
//
// Contract
// - four sources, each with own enable
// - each source has readable status flag
// - speech, hr timer: 8-bit preload counters
// - general timer: 4-bit preload counter
// - external flag on pad rising edge
`timescale 1ns/1ps
`include "four_source_irq_map.svh"

module four_source_interrupt_unit (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire four_source_irq_pkg::bus_req_s    bus_req,
  output logic      [`FSI_DATA_W-1:0]           rdata,
  input  wire logic                             input_port_bit3_pad,
  output logic      [`FSI_NUM_SRC-1:0]          pending,
  output logic                                  irq_req
);

  four_source_irq_pkg::unit_state_s q;
  four_source_irq_pkg::unit_state_s d;

  logic [`FSI_WIDE_CNT_W-1:0]   cnt_sp;
  logic [`FSI_WIDE_CNT_W-1:0]   cnt_hr;
  logic [`FSI_NARROW_CNT_W-1:0] cnt_tm;
  logic                         tc_sp;
  logic                         tc_hr;
  logic                         tc_tm;
  logic                         ext_rise;
  logic [`FSI_NUM_SRC-1:0]      events;
  logic [`FSI_NUM_SRC-1:0]      clr;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic wr_at(input four_source_irq_pkg::bus_req_s r,
                                 input logic [`FSI_ADDR_W-1:0] a);
    return r.we && (r.addr == a);
  endfunction

  function automatic logic [`FSI_DATA_W-1:0] pad4(input logic [3:0] v);
    return {4'h0, v};
  endfunction

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  preload_counter #(.W(`FSI_WIDE_CNT_W)) u_cnt_sp (
    .clk      (clk),
    .rst      (rst),
    .run      (q.run[`FSI_SRC_SPEECH]),
    .preload  (q.pre_sp),
    .count    (cnt_sp),
    .terminal (tc_sp)
  );

  preload_counter #(.W(`FSI_WIDE_CNT_W)) u_cnt_hr (
    .clk      (clk),
    .rst      (rst),
    .run      (q.run[`FSI_SRC_HRTIMER]),
    .preload  (q.pre_hr),
    .count    (cnt_hr),
    .terminal (tc_hr)
  );

  preload_counter #(.W(`FSI_NARROW_CNT_W)) u_cnt_tm (
    .clk      (clk),
    .rst      (rst),
    .run      (q.run[`FSI_SRC_TIMER]),
    .preload  (q.pre_tm),
    .count    (cnt_tm),
    .terminal (tc_tm)
  );

  // ----------------------------------------------------------------
  // events and clears
  // ----------------------------------------------------------------
  assign ext_rise = q.ext_sync[1] && !q.ext_sync[2];
  assign events   = {ext_rise, tc_tm, tc_hr, tc_sp};
  assign clr      = wr_at(bus_req, `FSI_ADDR_STATUS) ?
                    bus_req.wdata[`FSI_NUM_SRC-1:0] : 4'h0;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.ext_sync = {q.ext_sync[1:0], input_port_bit3_pad};
    d.status   = (q.status & ~clr) | events;
    if (wr_at(bus_req, `FSI_ADDR_ENABLE)) begin
      d.enable = bus_req.wdata[`FSI_NUM_SRC-1:0];
    end
    if (wr_at(bus_req, `FSI_ADDR_PRE_SP)) begin
      d.pre_sp = bus_req.wdata;
    end
    if (wr_at(bus_req, `FSI_ADDR_PRE_HR)) begin
      d.pre_hr = bus_req.wdata;
    end
    if (wr_at(bus_req, `FSI_ADDR_PRE_TM)) begin
      d.pre_tm = bus_req.wdata[`FSI_NARROW_CNT_W-1:0];
    end
    if (wr_at(bus_req, `FSI_ADDR_RUN)) begin
      d.run = bus_req.wdata[2:0];
    end
    d.rdata = `FSI_RDATA_RST;
    if (bus_req.re) begin
      if (bus_req.addr == `FSI_ADDR_ENABLE) begin
        d.rdata = pad4(q.enable);
      end else if (bus_req.addr == `FSI_ADDR_STATUS) begin
        d.rdata = pad4(q.status);
      end else if (bus_req.addr == `FSI_ADDR_PRE_SP) begin
        d.rdata = q.pre_sp;
      end else if (bus_req.addr == `FSI_ADDR_PRE_HR) begin
        d.rdata = q.pre_hr;
      end else if (bus_req.addr == `FSI_ADDR_PRE_TM) begin
        d.rdata = pad4(q.pre_tm);
      end else if (bus_req.addr == `FSI_ADDR_RUN) begin
        d.rdata = {5'h00, q.run};
      end else if (bus_req.addr == `FSI_ADDR_CNT_SP) begin
        d.rdata = cnt_sp;
      end else if (bus_req.addr == `FSI_ADDR_CNT_HR) begin
        d.rdata = cnt_hr;
      end else if (bus_req.addr == `FSI_ADDR_CNT_TM) begin
        d.rdata = pad4(cnt_tm);
      end else begin
        d.rdata = `FSI_RDATA_RST;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      q.enable   <= `FSI_ENABLE_RST;
      q.status   <= `FSI_STATUS_RST;
      q.pre_sp   <= `FSI_PRE_WIDE_RST;
      q.pre_hr   <= `FSI_PRE_WIDE_RST;
      q.pre_tm   <= `FSI_PRE_NARROW_RST;
      q.run      <= `FSI_RUN_RST;
      q.ext_sync <= `FSI_SYNC_RST;
      q.rdata    <= `FSI_RDATA_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata   = q.rdata;
  assign pending = q.status & q.enable;
  assign irq_req = |pending;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ext_edge_flag: assert property (q.ext_sync[1] && !q.ext_sync[2] |=>
      q.status[`FSI_SRC_EXTERNAL])
    else $error("pad rising edge did not set external flag");

  a_ext_pad_delay: assert property ($rose(input_port_bit3_pad) ##1
      input_port_bit3_pad[*2] |=> q.status[`FSI_SRC_EXTERNAL])
    else $error("held pad rise not flagged within three cycles");

  a_sp_flag_set: assert property (tc_sp |=> q.status[`FSI_SRC_SPEECH])
    else $error("speech terminal did not set flag");

  a_tm_flag_set: assert property (tc_tm |=> q.status[`FSI_SRC_TIMER])
    else $error("timer terminal did not set flag");

  a_hr_flag_set: assert property (tc_hr |=> q.status[`FSI_SRC_HRTIMER])
    else $error("hr timer terminal did not set flag");

  a_ext_only_rise: assert property (!ext_rise && !q.status[`FSI_SRC_EXTERNAL] |=>
      !q.status[`FSI_SRC_EXTERNAL])
    else $error("external flag set without a pad rise");

  a_flag_sticky: assert property ($fell(q.status[`FSI_SRC_HRTIMER]) |->
      $past(bus_req.we) && $past(bus_req.addr) == `FSI_ADDR_STATUS &&
      $past(bus_req.wdata[`FSI_SRC_HRTIMER]))
    else $error("flag dropped without a clearing write");

  a_set_wins: assert property (tc_hr && clr[`FSI_SRC_HRTIMER] |=>
      q.status[`FSI_SRC_HRTIMER])
    else $error("event lost against simultaneous clear");

  a_irq_gate: assert property ($fell(irq_req) |-> $past(bus_req.we) &&
      ($past(bus_req.addr) == `FSI_ADDR_ENABLE ||
       $past(bus_req.addr) == `FSI_ADDR_STATUS))
    else $error("request dropped without enable or status write");

  a_masked_quiet: assert property (tc_sp && !q.enable[`FSI_SRC_SPEECH] &&
      !bus_req.we |=> !pending[`FSI_SRC_SPEECH])
    else $error("disabled source reached the core");

  a_read_enable: assert property (bus_req.re && bus_req.addr == `FSI_ADDR_ENABLE |=>
      rdata == pad4($past(q.enable)))
    else $error("enable readback wrong");

  a_read_status: assert property (bus_req.re && bus_req.addr == `FSI_ADDR_STATUS |=>
      rdata == pad4($past(q.status)))
    else $error("status readback wrong");

  c_speech_tc: cover property (tc_sp ##1 irq_req);
  c_ext_edge: cover property (ext_rise ##1 q.status[`FSI_SRC_EXTERNAL]);
  c_set_clear: cover property (tc_tm && clr[`FSI_SRC_TIMER]);
  c_timer_irq: cover property ($rose(irq_req) && pending[`FSI_SRC_TIMER]);
  c_set_wins: cover property (tc_hr && clr[`FSI_SRC_HRTIMER]);

endmodule

// *** tb/core_model.sv ***
/*
  model of the processor core on the register port: single cycle
  writes and reads, read data taken one cycle after the strobe.
  assumes: clk shared with the unit; the bench calls wr and rd.
*/
`timescale 1ns/1ps
`include "four_source_irq_map.svh"

module core_model (
  input  wire logic                     clk,
  input  wire logic [`FSI_DATA_W-1:0]   rdata,
  input  wire logic                     irq_req,
  output four_source_irq_pkg::bus_req_s bus_req
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  int irq_seen;

  initial begin
    bus_req = '0;
    irq_seen = 0;
  end

  always @(posedge clk) begin
    if (irq_req === 1'b1) irq_seen <= irq_seen + 1;
  end

  task automatic wr(input logic [`FSI_ADDR_W-1:0] a, input logic [`FSI_DATA_W-1:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge clk);
    bus_req <= '{addr: ~a, wdata: ~v, we: 1'b0, re: 1'b0};
  endtask

  task automatic rd(input logic [`FSI_ADDR_W-1:0] a, output logic [`FSI_DATA_W-1:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h5A, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus_req <= '{addr: ~a, wdata: 8'hA5, we: 1'b0, re: 1'b0};
    #1 v = rdata;
  endtask
endmodule

// *** tb/testbench.sv ***
/*
  self-checking bench of the four source interrupt unit.
  assumes: core_model drives the register port; bench drives pad.
*/
`timescale 1ns/1ps
`include "four_source_irq_map.svh"

module testbench;
  logic                          clk;
  logic                          rst;
  logic                          input_port_bit3_pad;
  four_source_irq_pkg::bus_req_s bus_req;
  logic [`FSI_DATA_W-1:0]        rdata;
  logic [`FSI_NUM_SRC-1:0]       pending;
  logic                          irq_req;
  logic [`FSI_DATA_W-1:0]        d;
  int                            n;
  int                            error_cnt;
  int                            total_checks;

  four_source_interrupt_unit dut (
    .clk                 (clk),
    .rst                 (rst),
    .bus_req             (bus_req),
    .rdata               (rdata),
    .input_port_bit3_pad (input_port_bit3_pad),
    .pending             (pending),
    .irq_req             (irq_req)
  );

  core_model core (
    .clk     (clk),
    .rdata   (rdata),
    .irq_req (irq_req),
    .bus_req (bus_req)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_pend(input int src);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (pending[src] !== 1'b1 && n < 300);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int a = 0; a <= 8; a++) begin
      core.rd(4'(a), d);
      check("reset value", d, 8'h00);
    end
    core.rd(4'hF, d);
    check("unmapped read", d, 8'h00);
    core.wr(`FSI_ADDR_PRE_SP, 8'h3C);
    core.rd(`FSI_ADDR_PRE_SP, d);
    check("speech preload", d, 8'h3C);
    @(posedge clk);
    #1 check("rdata one cycle", rdata, 8'h00);
    core.wr(`FSI_ADDR_PRE_TM, 8'hF7);
    core.rd(`FSI_ADDR_PRE_TM, d);
    check("timer preload width", d, 8'h07);
    $display("test regs done");
  endtask

  task automatic t_period(input int src, input logic [3:0] pa, input logic [7:0] wv, input int p);
    logic [7:0] bit_m;
    bit_m = 8'(1 << src);
    core.wr(pa, wv);
    core.wr(`FSI_ADDR_ENABLE, bit_m);
    core.wr(`FSI_ADDR_RUN, bit_m);
    wait_pend(src);
    check("first terminal", 8'(n), 8'(p + 1));
    check("irq raised", {7'h00, irq_req}, 8'h01);
    core.wr(`FSI_ADDR_STATUS, bit_m);
    wait_pend(src);
    check("reload period", 8'(n), 8'(p - 2));
    core.rd(`FSI_ADDR_STATUS, d);
    check("status flag", d, bit_m);
    core.wr(`FSI_ADDR_RUN, 8'h00);
    core.wr(`FSI_ADDR_STATUS, 8'h0F);
    core.wr(`FSI_ADDR_ENABLE, 8'h00);
    $display("test period %0d done", src);
  endtask

  task automatic t_mask();
    int seen0;
    seen0 = core.irq_seen;
    core.wr(`FSI_ADDR_PRE_TM, 8'h0E);
    core.wr(`FSI_ADDR_ENABLE, 8'h0B);
    core.wr(`FSI_ADDR_RUN, 8'h04);
    repeat (10) @(posedge clk);
    #1 check("masked pending", {4'h0, pending}, 8'h00);
    check("masked irq", {7'h00, irq_req}, 8'h00);
    check("core irq cycles", 8'(core.irq_seen - seen0), 8'h00);
    core.rd(`FSI_ADDR_STATUS, d);
    check("masked status", d, 8'h04);
    core.wr(`FSI_ADDR_ENABLE, 8'h04);
    #1 check("unmasked pending", {4'h0, pending}, 8'h04);
    check("unmasked irq", {7'h00, irq_req}, 8'h01);
    core.wr(`FSI_ADDR_RUN, 8'h00);
    core.wr(`FSI_ADDR_STATUS, 8'h0F);
    core.rd(`FSI_ADDR_CNT_TM, d);
    check("stopped timer count", d, 8'h0E);
    core.wr(`FSI_ADDR_PRE_HR, 8'hFF);
    core.wr(`FSI_ADDR_ENABLE, 8'h02);
    core.wr(`FSI_ADDR_RUN, 8'h03);
    core.wr(`FSI_ADDR_STATUS, 8'h02);
    #1 check("set beats clear", {4'h0, pending}, 8'h02);
    repeat (10) @(posedge clk);
    core.rd(`FSI_ADDR_STATUS, d);
    check("masked speech flag", d, 8'h03);
    core.wr(`FSI_ADDR_RUN, 8'h00);
    core.wr(`FSI_ADDR_STATUS, 8'h0F);
    $display("test mask done");
  endtask

  task automatic t_ext();
    core.wr(`FSI_ADDR_ENABLE, 8'h08);
    @(posedge clk);
    input_port_bit3_pad <= 1'b1;
    wait_pend(3);
    check("pad rise latency", 8'(n >= 3 && n <= 5), 8'h01);
    core.wr(`FSI_ADDR_STATUS, 8'h08);
    @(posedge clk);
    input_port_bit3_pad <= 1'b0;
    repeat (10) @(posedge clk);
    #1 check("pad fall ignored", {4'h0, pending}, 8'h00);
    core.rd(`FSI_ADDR_STATUS, d);
    check("pad fall status", d, 8'h00);
    $display("test external done");
  endtask

  task automatic t_rereset();
    core.wr(`FSI_ADDR_PRE_SP, 8'hFE);
    core.wr(`FSI_ADDR_ENABLE, 8'h0F);
    core.wr(`FSI_ADDR_RUN, 8'h07);
    repeat (6) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check("reset pending", {4'h0, pending}, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    core.rd(`FSI_ADDR_RUN, d);
    check("reset run", d, 8'h00);
    core.rd(`FSI_ADDR_STATUS, d);
    check("reset status", d, 8'h00);
    $display("test rereset done");
  endtask

  // ----------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    input_port_bit3_pad = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_period(`FSI_SRC_SPEECH, `FSI_ADDR_PRE_SP, 8'hF8, 8);
    t_period(`FSI_SRC_HRTIMER, `FSI_ADDR_PRE_HR, 8'hF0, 16);
    t_period(`FSI_SRC_TIMER, `FSI_ADDR_PRE_TM, 8'hF0, 16);
    t_mask();
    t_ext();
    t_rereset();
    final_report();
  end
endmodule
